// file: core/rrx_pkg.sv
// Package of constants and carriers for the return and rotate executor
package rrx_pkg;

  localparam int          RRX_IW_W        = 14;
  localparam int          RRX_PC_W        = 13;
  localparam int          RRX_FA_W        = 7;
  // Opcode patterns and masks
  localparam logic [13:0] RRX_LITRET_MASK = 14'h3C00;
  localparam logic [13:0] RRX_LITRET_OP   = 14'h3400;
  localparam logic [13:0] RRX_SUBRET_OP   = 14'h0008;
  localparam logic [13:0] RRX_ROTL_MASK   = 14'h3F00;
  localparam logic [13:0] RRX_ROTL_OP     = 14'h0D00;
  // Field positions
  localparam int          RRX_DEST_BIT    = 7;
  // Cycle counts
  localparam logic [1:0]  RRX_RET_CYCLES  = 2'h2;
  localparam logic [1:0]  RRX_ROTL_CYCLES = 2'h1;
  // Reset values
  localparam logic [7:0]  RRX_W_RST       = 8'h00;
  localparam logic [12:0] RRX_PC_RST      = 13'h0000;

  typedef enum logic [1:0] {
    RRX_OP_NONE   = 2'b00,
    RRX_OP_LITRET = 2'b01,
    RRX_OP_SUBRET = 2'b10,
    RRX_OP_ROTL   = 2'b11
  } rrx_op_e;

  typedef struct packed {
    logic                valid;
    logic [13:0]         word;
  } rrx_instr_s;

  typedef struct packed {
    logic                req;
    logic [6:0]          addr;
    logic [7:0]          data;
  } rrx_fwrite_s;

  typedef enum logic [1:0] {
    RRX_ST_IDLE  = 2'b00,
    RRX_ST_FLUSH = 2'b01
  } rrx_state_e;

endpackage : rrx_pkg

// file: core/rrx_decode.sv
// Opcode classifier for the return and rotate executor
`timescale 1ns/1ps
module rrx_decode
  import rrx_pkg::*;
(
  input  wire rrx_pkg::rrx_instr_s instr,
  output rrx_pkg::rrx_op_e         op
);
  always_comb begin
    op = RRX_OP_NONE;
    if (instr.valid) begin
      if ((instr.word & RRX_LITRET_MASK) == RRX_LITRET_OP) begin
        op = RRX_OP_LITRET;
      end else if (instr.word == RRX_SUBRET_OP) begin
        op = RRX_OP_SUBRET;
      end else if ((instr.word & RRX_ROTL_MASK) == RRX_ROTL_OP) begin
        op = RRX_OP_ROTL;
      end
    end
  end
endmodule : rrx_decode

// file: core/rrx_exec.sv
// Executor for literal return, subroutine return and rotate left through carry
`timescale 1ns/1ps

// Summary of operation
// - Literal return loads the 8-bit immediate into the working register, bits 9:8 ignored.
// - Literal return pops the return stack and loads its top entry into the program counter.
// - Literal return is one word, two cycles, and changes no status flag.
// - Subroutine return pops the stack into the program counter, W and flags untouched.
// - Subroutine return is one word and takes two cycles before execution resumes.
// - Rotate left shifts the file value left, old carry into bit 0, old bit 7 to carry.
// - Rotate left writes W when the destination bit is 0, the file register when 1.
module rrx_exec (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire rrx_pkg::rrx_instr_s instr,
  input  wire logic [12:0]         stack_top,
  input  wire logic [7:0]          file_rdata,
  input  wire logic                carry_in,
  input  wire logic [7:0]          w_in,
  output logic                     instr_ready,
  output logic [6:0]               file_raddr,
  output logic                     stack_pop,
  output logic                     pc_load,
  output logic [12:0]              pc_value,
  output logic [7:0]               w_out,
  output logic                     w_write,
  output logic                     carry_out,
  output logic                     carry_write,
  output rrx_pkg::rrx_fwrite_s     file_write
);
  import rrx_pkg::*;

  // ==========================================
  // Helpers
  function automatic logic is_ret(input rrx_op_e o);
    return (o == RRX_OP_LITRET) || (o == RRX_OP_SUBRET);
  endfunction : is_ret

  // ==========================================
  // Decode
  rrx_op_e    op;
  rrx_state_e state_r;
  logic       take;
  logic [7:0] rot;

  rrx_decode u_dec (
    .instr (instr),
    .op    (op)
  );

  assign take = (state_r == RRX_ST_IDLE);
  assign file_raddr = instr.word[RRX_FA_W-1:0];
  assign rot = {file_rdata[6:0], carry_in};

  // ==========================================
  // Two-cycle return sequencing
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r     <= RRX_ST_IDLE;
      instr_ready <= 1'b1;
    end else begin
      case (state_r)
        RRX_ST_IDLE: begin
          if (is_ret(op)) begin
            state_r     <= RRX_ST_FLUSH;
            instr_ready <= 1'b0;
          end
        end
        RRX_ST_FLUSH: begin
          state_r     <= RRX_ST_IDLE;
          instr_ready <= 1'b1;
        end
        default: begin
          state_r     <= RRX_ST_IDLE;
          instr_ready <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================
  // Program counter and stack
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stack_pop <= 1'b0;
      pc_load   <= 1'b0;
      pc_value  <= RRX_PC_RST;
    end else begin
      stack_pop <= take && is_ret(op);
      pc_load   <= take && is_ret(op);
      if (take && is_ret(op)) begin
        pc_value <= stack_top;
      end
    end
  end

  // ==========================================
  // Working register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      w_out   <= RRX_W_RST;
      w_write <= 1'b0;
    end else begin
      w_write <= 1'b0;
      w_out   <= w_in;
      if (take && op == RRX_OP_LITRET) begin
        w_out   <= instr.word[7:0];
        w_write <= 1'b1;
      end else if (take && op == RRX_OP_ROTL && !instr.word[RRX_DEST_BIT]) begin
        w_out   <= rot;
        w_write <= 1'b1;
      end
    end
  end

  // ==========================================
  // File register and carry
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      file_write  <= '0;
      carry_out   <= 1'b0;
      carry_write <= 1'b0;
    end else begin
      file_write.req  <= 1'b0;
      file_write.addr <= instr.word[RRX_FA_W-1:0];
      file_write.data <= rot;
      carry_write     <= 1'b0;
      carry_out       <= carry_in;
      if (take && op == RRX_OP_ROTL) begin
        carry_out   <= file_rdata[7];
        carry_write <= 1'b1;
        file_write.req <= instr.word[RRX_DEST_BIT];
      end
    end
  end

endmodule : rrx_exec

// file: tb/rrx_exec_sva.sv
// Checker for the return and rotate executor
`timescale 1ns/1ps
module rrx_exec_sva
  import rrx_pkg::*;
(
  input logic clk,
  input logic rst_b,
  input rrx_pkg::rrx_instr_s instr,
  input logic [12:0] stack_top,
  input logic [7:0] file_rdata,
  input logic carry_in,
  input logic instr_ready,
  input logic stack_pop,
  input logic pc_load,
  input logic [12:0] pc_value,
  input logic [7:0] w_out,
  input logic w_write,
  input logic carry_out,
  input logic carry_write,
  input rrx_pkg::rrx_fwrite_s file_write
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire tk = instr.valid && instr_ready;
  wire lr = tk && (instr.word & RRX_LITRET_MASK) == RRX_LITRET_OP;
  wire sr = tk && instr.word == RRX_SUBRET_OP;
  wire rl = tk && (instr.word & RRX_ROTL_MASK) == RRX_ROTL_OP;
  wire dd = instr.word[RRX_DEST_BIT];
  sequence s_pop; stack_pop && pc_load && pc_value == $past(stack_top); endsequence
  sequence s_gap; !instr_ready ##1 instr_ready; endsequence
  a_lit_w: assert property (lr |=> w_write && w_out == $past(instr.word[7:0]))
    else $error("lit w");
  a_ret_pop: assert property (lr || sr |=> s_pop) else $error("pop");
  a_ret_gap: assert property (lr || sr |=> s_gap) else $error("gap");
  a_ret_flags: assert property (lr || sr |=> !carry_write && w_write == $past(lr))
    else $error("ret flags");
  a_rot_carry: assert property (rl |=> carry_write && carry_out == $past(file_rdata[7]))
    else $error("carry");
  a_rot_file: assert property (rl && dd |=> !w_write && file_write ==
    {1'b1, $past(instr.word[6:0]), $past(file_rdata[6:0]), $past(carry_in)}) else $error("f");
  a_rot_w: assert property (rl && !dd |=> !file_write.req && w_write
    && w_out == {$past(file_rdata[6:0]), $past(carry_in)}) else $error("w");
  a_rot_one: assert property (rl |=> instr_ready && !stack_pop) else $error("one");
endmodule : rrx_exec_sva
bind rrx_exec rrx_exec_sva rrx_exec_sva_inst (.*);

// file: tb/rrx_far.sv
// Far-side model: file registers, carry flag and working register
`timescale 1ns/1ps
module rrx_far
  import rrx_pkg::*;
(
  input logic clk,
  input logic [6:0] file_raddr,
  input rrx_pkg::rrx_fwrite_s file_write,
  input logic carry_out,
  input logic carry_write,
  input logic [7:0] w_out,
  input logic w_write,
  output logic [7:0] file_rdata,
  output logic carry_in,
  output logic [7:0] w_in
);
  logic [7:0] mem [128];
  assign file_rdata = mem[file_raddr];
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
    carry_in = 1'b1;
    w_in = 8'h5A;
  end
  always @(posedge clk) begin
    if (file_write.req) mem[file_write.addr] <= file_write.data;
    if (carry_write) carry_in <= carry_out;
    if (w_write) w_in <= w_out;
  end
endmodule : rrx_far

// file: tb/tb.sv
// Self-checking bench for the return and rotate executor
`timescale 1ns/1ps
module tb;
  import rrx_pkg::*;
  logic clk = 0, rst_b = 0, carry_in, instr_ready, stack_pop, pc_load, w_write;
  logic carry_out, carry_write;
  rrx_instr_s instr = '0;
  rrx_fwrite_s file_write;
  logic [12:0] stack_top = '0, pc_value;
  logic [7:0] file_rdata, w_in, w_out;
  logic [6:0] file_raddr;
  logic [31:0] seed = 32'h1BDC4868;
  int bad_count = 0, total_checks = 0;
  rrx_exec rrx_exec_inst (.*);
  rrx_far rrx_far_inst (.*);
  always #2 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic exec(input logic [13:0] wd);
    logic [7:0] f;
    logic c;
    instr = {1'b1, wd};
    stack_top = seed[28:16];
    f = rrx_far_inst.mem[wd[6:0]];
    c = carry_in;
    @(posedge clk);
    #1;
    if ((wd & RRX_LITRET_MASK) == RRX_LITRET_OP || wd == RRX_SUBRET_OP) begin
      check(16'(pc_value), 16'(stack_top));
      check({stack_pop, pc_load, w_write, instr_ready, carry_write}, {2'h3, wd[13], 2'h0});
      if (wd[13]) check(16'(w_out), 16'(wd[7:0]));
      instr = '0;
      @(posedge clk);
      #1;
      check(16'(instr_ready), 16'h0001);
    end else if ((wd & RRX_ROTL_MASK) == RRX_ROTL_OP) begin
      check({instr_ready, carry_write, carry_out, wd[7] ? file_write.data : w_out,
             file_write.req, w_write}, {2'h3, f, c, wd[7], ~wd[7]});
      check(16'(file_write.addr), 16'(wd[6:0]));
    end else
      check({w_write, pc_load, carry_write, file_write.req}, 16'h0000);
  endtask : exec
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_b = 1;
    @(posedge clk);
    #1;
    exec(14'h0DFF);
    exec(14'h0D7F);
    exec(14'h3FFF);
    for (int i = 0; i < 400; i++) begin
      seed = xs(seed);
      case (seed[1:0])
        2'h0: exec({4'hD, seed[11:2]});
        2'h1: exec(RRX_SUBRET_OP);
        2'h2: exec({6'h0D, seed[9:2]});
        default: exec(seed[15:2]);
      endcase
    end
    tally_and_finish();
  end
  initial begin
    #8000;
    bad_count++;
    tally_and_finish();
  end
endmodule : tb
